// [rtl/hdep_fifo.sv]
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: single clock, depth a power of two
// Notes: write and read in one cycle allowed when neither empty nor full
`timescale 1ns/1ps
`default_nettype none
module hdep_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  // full and empty come straight from the occupancy count
  assign in_ready_o = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign push = ce_i && in_valid_i && in_ready_o;
  assign pop = ce_i && out_valid_o && out_ready_i;
  assign out_data_o = mem[rd_ptr_reg];

  // storage has no reset, pointers do
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      end
      if (push && !pop) begin
        count_reg <= count_reg + (AW+1)'(1);
      end else if (pop && !push) begin
        count_reg <= count_reg - (AW+1)'(1);
      end
    end
  end
endmodule
`default_nettype wire

// [rtl/hdep_path.sv]
// Purpose: assemble 16-bit host halves into dwords and order their bytes
// Assumes: host accesses arrive as one-cycle strobes on CLK_I
// Notes: written dwords pass a fifo; reads serve halves of a fetched dword
// Functional notes
// - write halves may come in either order, the second to the other half.
// - a write to the same half as the previous write discards the pair.
// - reads are two 16-bit reads inside one dword, either order, other half second.
// - reading the same half twice restarts the read pair at the next read.
// - port window data accesses are little endian, big endian when its bit is set.
// - select input data accesses use their own endian bit in the same way.
// - csr and status fifo accesses ignore both endian bits.
// - half swap applies to csr, status and data accesses, reads and writes.
// - writes swap halves then reorder bytes; reads reorder then swap.
// - the internal word holds bytes 3-2-1-0, byte 3 in bits 31:24.
`timescale 1ns/1ps
`default_nettype none
module hdep_path #(
  parameter int DEPTH = hdep_pkg::FIFO_DEPTH
) (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic CE_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic HALFWORD_SELECT_ADDRESS_I,
  input wire logic [1:0] KIND_I,
  input wire logic [15:0] WDATA_I,
  output logic [15:0] RDATA_O,
  output logic RDATA_VALID_O,
  input wire logic FIFO_PORT_BIG_ENDIAN_I,
  input wire logic FIFO_SELECT_BIG_ENDIAN_I,
  input wire logic [31:0] WORD_SWAP_I,
  output logic WR_READY_O,
  output logic WR_DISCARD_O,
  output logic RD_BROKEN_O,
  output logic WORD_VALID_O,
  input wire logic WORD_READY_I,
  output logic [31:0] WORD_DATA_O,
  output logic [1:0] WORD_KIND_O,
  input wire logic [31:0] RD_WORD_I,
  output logic RD_WORD_REQ_O
);
  logic wr_seen_reg;
  logic wr_half_reg;
  logic [15:0] wr_first_reg;
  logic rd_seen_reg;
  logic rd_half_reg;
  logic [31:0] rd_word_reg;
  logic push_valid;
  logic push_ready;
  logic [31:0] push_word;
  logic [33:0] fifo_out;
  logic swap_on;
  // per-access decode shared by the pairing and the output logic
  logic wr_take;
  logic wr_same;
  logic rd_take;
  logic rd_same;
  logic [31:0] rd_src;
  logic [31:0] rd_ord;
  logic [31:0] rd_sw;
  logic [15:0] rdata_next;

  // byte reversal of a dword, byte 3 in the top lane
  function automatic logic [31:0] byte_rev(input logic [31:0] d);
    byte_rev = {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction

  // endian select per access kind; csr/status never reorders
  function automatic logic big_for(input logic [1:0] k, input logic pe, input logic se);
    big_for = (k == hdep_pkg::KIND_PORT) ? pe :
              (k == hdep_pkg::KIND_SEL) ? se : 1'b0;
  endfunction

  // half swap of a dword, shared by the write and read paths
  function automatic logic [31:0] half_swap(input logic [31:0] d, input logic on);
    half_swap = on ? {d[15:0], d[31:16]} : d;
  endfunction

  // byte reorder for the access kind, the same map in both directions
  function automatic logic [31:0] order_bytes(input logic [31:0] d, input logic [1:0] k,
                                              input logic pe, input logic se);
    order_bytes = big_for(k, pe, se) ? byte_rev(d) : d;
  endfunction

  // swap needs the exact all-ones value, a partial pattern is ignored
  assign swap_on = (WORD_SWAP_I == hdep_pkg::SWAP_ALL_ONES);

  // write assembly: lane chosen by address bit 1, halves swapped, then reorder
  always_comb begin
    logic [31:0] raw;
    logic [31:0] sw;
    raw = hdep_pkg::RST_WORD;
    sw = hdep_pkg::RST_WORD;
    if (HALFWORD_SELECT_ADDRESS_I) begin
      raw = {WDATA_I, wr_first_reg};
    end else begin
      raw = {wr_first_reg, WDATA_I};
    end
    sw = half_swap(raw, swap_on);
    push_word = order_bytes(sw, KIND_I, FIFO_PORT_BIG_ENDIAN_I,
                            FIFO_SELECT_BIG_ENDIAN_I);
  end

  // second half to the other lane completes the dword
  assign push_valid = CE_I && WR_I && wr_seen_reg &&
                      (HALFWORD_SELECT_ADDRESS_I != wr_half_reg);
  // stall the host while a completing write cannot enter the fifo
  assign WR_READY_O = push_ready || !wr_seen_reg;

  // a write is taken when no half is held or the fifo can accept an entry
  assign wr_take = CE_I && WR_I && WR_READY_O;
  // a second half aimed at the lane already held breaks the pair
  assign wr_same = wr_seen_reg && (HALFWORD_SELECT_ADDRESS_I == wr_half_reg);

  // write half tracking; a same-half write throws the pair away
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      wr_seen_reg <= hdep_pkg::RST_HALF_SEEN;
      wr_half_reg <= 1'b0;
      wr_first_reg <= hdep_pkg::RST_HALF;
    end else if (wr_take) begin
      if (!wr_seen_reg) begin
        wr_seen_reg <= 1'b1;
        wr_half_reg <= HALFWORD_SELECT_ADDRESS_I;
        wr_first_reg <= WDATA_I;
      end else begin
        wr_seen_reg <= 1'b0;
      end
    end
  end

  // discard pulse lasts one enabled cycle
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      WR_DISCARD_O <= 1'b0;
    end else if (CE_I) begin
      WR_DISCARD_O <= wr_take && wr_same;
    end
  end

  // entries carry the kind above the dword so the sink can route it
  hdep_fifo #(
    .WIDTH(34),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .ce_i(CE_I),
    .in_valid_i(push_valid),
    .in_ready_o(push_ready),
    .in_data_i({KIND_I, push_word}),
    .out_valid_o(WORD_VALID_O),
    .out_ready_i(WORD_READY_I),
    .out_data_o(fifo_out)
  );
  // split the fifo entry back into dword and kind
  assign WORD_DATA_O = fifo_out[31:0];
  assign WORD_KIND_O = fifo_out[33:32];

  // fetch a new dword on the first read of each pair
  assign RD_WORD_REQ_O = CE_I && RD_I && !rd_seen_reg;

  // reads are never refused; a same-half partner breaks the pair
  assign rd_take = CE_I && RD_I;
  assign rd_same = rd_seen_reg && (HALFWORD_SELECT_ADDRESS_I == rd_half_reg);

  // read pairing: hold the fetched dword for the partner read
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      rd_seen_reg <= hdep_pkg::RST_HALF_SEEN;
      rd_half_reg <= 1'b0;
      rd_word_reg <= hdep_pkg::RST_WORD;
    end else if (rd_take) begin
      if (!rd_seen_reg) begin
        rd_seen_reg <= 1'b1;
        rd_half_reg <= HALFWORD_SELECT_ADDRESS_I;
        rd_word_reg <= RD_WORD_I;
      end else begin
        rd_seen_reg <= 1'b0;
      end
    end
  end

  // broken pulse; the next read then fetches afresh
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      RD_BROKEN_O <= 1'b0;
    end else if (CE_I) begin
      RD_BROKEN_O <= rd_take && rd_same;
    end
  end

  // read data path: reorder bytes first, then swap halves, then pick the lane
  always_comb begin
    rd_src = rd_seen_reg ? rd_word_reg : RD_WORD_I;
    rd_ord = order_bytes(rd_src, KIND_I, FIFO_PORT_BIG_ENDIAN_I, FIFO_SELECT_BIG_ENDIAN_I);
    rd_sw = half_swap(rd_ord, swap_on);
    rdata_next = HALFWORD_SELECT_ADDRESS_I ? rd_sw[31:16] : rd_sw[15:0];
  end

  // read half register, held until the next read
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      RDATA_O <= hdep_pkg::RST_HALF;
    end else if (rd_take) begin
      RDATA_O <= rdata_next;
    end
  end

  // valid follows every enabled read by one cycle
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      RDATA_VALID_O <= 1'b0;
    end else if (CE_I) begin
      RDATA_VALID_O <= RD_I;
    end
  end
endmodule
`default_nettype wire

// [rtl/hdep_pkg.sv]
// Purpose: shared constants for the host dword endian path
// Assumes: 16-bit host bus, 32-bit internal words
// Notes: access kinds select which endian control applies
package hdep_pkg;
  localparam int HALF_W = 16;
  localparam int WORD_W = 32;
  localparam int FIFO_DEPTH = 16;
  localparam logic [31:0] SWAP_ALL_ONES = 32'hFFFF_FFFF;
  localparam logic [1:0] KIND_PORT = 2'h0; // data fifo via port window
  localparam logic [1:0] KIND_SEL = 2'h1;  // data fifo via select input
  localparam logic [1:0] KIND_CSR = 2'h2;  // csr or status fifo
  localparam logic RST_HALF_SEEN = 1'b0;
  localparam logic [15:0] RST_HALF = 16'h0000;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  typedef enum logic [1:0] {HDEP_DIR_WR, HDEP_DIR_RD} hdep_dir_t;
endpackage

// [testbench/hdep_far.sv]
// Purpose: far side of hdep_path, word sink and dword source
// Assumes: one clock
// Notes: slow mode takes a word every other cycle
`timescale 1ns/1ps
`default_nettype none
module hdep_far (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic stall_i,
  input wire logic slow_i,
  input wire logic req_i,
  input wire logic [31:0] src_i,
  output logic ready_o,
  output logic [31:0] word_o
);
  logic t_reg;
  // toggle paces the slow sink
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) t_reg <= 1'b0;
    else t_reg <= !t_reg;
  end
  assign ready_o = !stall_i && (!slow_i || t_reg);
  // word only valid while fetched, inverse otherwise so stale use shows
  assign word_o = req_i ? src_i : ~src_i;
endmodule
`default_nettype wire

// [testbench/hdep_path_asserts.sv]
// Purpose: port checks for hdep_path
// Assumes: CE_I held high by the bench
// Notes: bound to every hdep_path instance
`timescale 1ns/1ps
`default_nettype none
module hdep_chk (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic RDATA_VALID_O,
  input wire logic WR_READY_O,
  input wire logic WR_DISCARD_O,
  input wire logic RD_BROKEN_O,
  input wire logic WORD_VALID_O,
  input wire logic WORD_READY_I,
  input wire logic [31:0] WORD_DATA_O,
  input wire logic RD_WORD_REQ_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  // every read answers next cycle
  property p_rv; RD_I |=> RDATA_VALID_O || RD_BROKEN_O; endproperty
  a_rv: assert property (p_rv) else $error("read not answered");
  property p_vr; RDATA_VALID_O |-> $past(RD_I); endproperty
  a_vr: assert property (p_vr) else $error("read data without read");
  // the partner read right after a fetch must use the held dword
  property p_req; RD_WORD_REQ_O ##1 RD_I |-> !RD_WORD_REQ_O; endproperty
  a_req: assert property (p_req) else $error("fetch on partner read");
  property p_wd; WR_DISCARD_O |-> $past(WR_I); endproperty
  a_wd: assert property (p_wd) else $error("discard without write");
  property p_rb; RD_BROKEN_O |-> $past(RD_I, 1); endproperty
  a_rb: assert property (p_rb) else $error("broken without read");
  // a read in the cycle right after a broken pair must refetch
  property p_rs; RD_BROKEN_O && RD_I |-> RD_WORD_REQ_O; endproperty
  a_rs: assert property (p_rs) else $error("no restart after broken");
  property p_hold;
    WORD_VALID_O && !WORD_READY_I |=> WORD_VALID_O && $stable(WORD_DATA_O);
  endproperty
  a_hold: assert property (p_hold) else $error("word dropped while stalled");
  property p_wr; !WR_READY_O |-> WORD_VALID_O; endproperty
  a_wr: assert property (p_wr) else $error("write refused with room");
endmodule
bind hdep_path hdep_chk u_chk (
  .CLK_I(CLK_I),
  .RESET_I(RESET_I),
  .WR_I(WR_I),
  .RD_I(RD_I),
  .RDATA_VALID_O(RDATA_VALID_O),
  .WR_READY_O(WR_READY_O),
  .WR_DISCARD_O(WR_DISCARD_O),
  .RD_BROKEN_O(RD_BROKEN_O),
  .WORD_VALID_O(WORD_VALID_O),
  .WORD_READY_I(WORD_READY_I),
  .WORD_DATA_O(WORD_DATA_O),
  .RD_WORD_REQ_O(RD_WORD_REQ_O)
);
`default_nettype wire

// [testbench/host_dword_endian_path_tb.sv]
// Purpose: self-checking bench for hdep_path
// Assumes: CE_I held high
// Notes: reference model works on whole host dwords
`timescale 1ns/1ps
`default_nettype none
module host_dword_endian_path_tb;
  logic CLK_I = 0, RESET_I, CE_I, WR_I, RD_I, ha, FIFO_PORT_BIG_ENDIAN_I, FIFO_SELECT_BIG_ENDIAN_I;
  logic RDATA_VALID_O, WR_READY_O, WR_DISCARD_O, RD_BROKEN_O, WORD_VALID_O, WORD_READY_I;
  logic RD_WORD_REQ_O, stall, slow, be, s, a;
  logic [1:0] KIND_I, WORD_KIND_O;
  logic [15:0] WDATA_I, RDATA_O, lf = 16'h003B;
  logic [31:0] WORD_SWAP_I, WORD_DATA_O, RD_WORD_I, src, h;
  logic [33:0] q[$];
  int failures = 0, checks = 0, cyc = 0;
  hdep_path uut (
    .CLK_I(CLK_I),
    .RESET_I(RESET_I),
    .CE_I(CE_I),
    .WR_I(WR_I),
    .RD_I(RD_I),
    .HALFWORD_SELECT_ADDRESS_I(ha),
    .KIND_I(KIND_I),
    .WDATA_I(WDATA_I),
    .RDATA_O(RDATA_O),
    .RDATA_VALID_O(RDATA_VALID_O),
    .FIFO_PORT_BIG_ENDIAN_I(FIFO_PORT_BIG_ENDIAN_I),
    .FIFO_SELECT_BIG_ENDIAN_I(FIFO_SELECT_BIG_ENDIAN_I),
    .WORD_SWAP_I(WORD_SWAP_I),
    .WR_READY_O(WR_READY_O),
    .WR_DISCARD_O(WR_DISCARD_O),
    .RD_BROKEN_O(RD_BROKEN_O),
    .WORD_VALID_O(WORD_VALID_O),
    .WORD_READY_I(WORD_READY_I),
    .WORD_DATA_O(WORD_DATA_O),
    .WORD_KIND_O(WORD_KIND_O),
    .RD_WORD_I(RD_WORD_I),
    .RD_WORD_REQ_O(RD_WORD_REQ_O)
  );
  hdep_far far (.clk_i(CLK_I), .reset_i(RESET_I), .stall_i(stall), .slow_i(slow),
    .req_i(RD_WORD_REQ_O), .src_i(src), .ready_o(WORD_READY_I), .word_o(RD_WORD_I));
  always #2.5 CLK_I = !CLK_I;
  function automatic logic [15:0] nx(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [31:0] sw(logic [31:0] x, logic e);
    return e ? {x[15:0], x[31:16]} : x;
  endfunction
  function automatic logic [31:0] rv(logic [31:0] x, logic e);
    return e ? {x[7:0], x[15:8], x[23:16], x[31:24]} : x;
  endfunction
  task automatic chk(string n, logic [33:0] e, logic [33:0] v);
    checks++;
    if (v !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, v);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // write one half, held until the edge that takes it
  task automatic hw(logic d_a, logic [15:0] d);
    logic r;
    WR_I = 1;
    RD_I = 0;
    ha = d_a;
    WDATA_I = d;
    do begin
      #1 r = WR_READY_O;
      @(negedge CLK_I);
    end while (!r);
  endtask
  task automatic rh(logic d_a, logic [31:0] e);
    RD_I = 1;
    WR_I = 0;
    ha = d_a;
    @(negedge CLK_I);
    chk("rdata", {1'b1, d_a ? e[31:16] : e[15:0]}, {RDATA_VALID_O, RDATA_O});
  endtask
  task automatic idle();
    WR_I = 0;
    RD_I = 0;
    @(negedge CLK_I);
  endtask
  // host dword in, expected internal word queued
  task automatic pair();
    lf = nx(lf);
    h = {lf, nx(lf)};
    lf = nx(lf);
    q.push_back({KIND_I, rv(sw(h, s), be)});
    hw(a, a ? h[31:16] : h[15:0]);
    hw(!a, a ? h[15:0] : h[31:16]);
  endtask
  always @(posedge CLK_I) begin
    cyc++;
    if (!RESET_I && WORD_VALID_O && WORD_READY_I) chk("word", q.pop_front(), {WORD_KIND_O, WORD_DATA_O});
    // the whole run needs a few hundred cycles
    if (cyc == 2000) begin
      failures++;
      wrap_up();
    end
  end
  initial begin
    {CE_I, RESET_I} = 2'h3;
    {WR_I, RD_I, ha, stall, slow, FIFO_PORT_BIG_ENDIAN_I, FIFO_SELECT_BIG_ENDIAN_I} = 7'h00;
    {KIND_I, WDATA_I, WORD_SWAP_I, src} = 82'h0;
    repeat (12) @(negedge CLK_I);
    RESET_I = 0;
    // kinds in rotation while the endian, swap and first-half bits step through all 16 settings
    for (int i = 0; i < 18; i++) begin
      KIND_I = 2'(i % 3);
      {s, FIFO_SELECT_BIG_ENDIAN_I, FIFO_PORT_BIG_ENDIAN_I, a} = 4'(i);
      slow = i[4];
      WORD_SWAP_I = s ? 32'hFFFF_FFFF : 32'hFFFF_FFFE;
      be = (KIND_I == 2'h0) ? FIFO_PORT_BIG_ENDIAN_I : (KIND_I == 2'h1) && FIFO_SELECT_BIG_ENDIAN_I;
      pair();
      src = {lf, ~lf};
      rh(a, sw(rv(src, be), s));
      rh(!a, sw(rv(src, be), s));
      idle();
    end
    // same half written twice: pair dropped
    hw(0, 16'h1234);
    hw(0, 16'h5678);
    chk("discard", 1'b1, WR_DISCARD_O);
    idle();
    pair();
    // same half read twice, then a fresh read pair
    rh(1, sw(rv(src, be), s));
    @(negedge CLK_I);
    chk("broken", 1'b1, RD_BROKEN_O);
    src = ~src + 32'h0000_0101;
    rh(0, sw(rv(src, be), s));
    rh(1, sw(rv(src, be), s));
    idle();
    // stalled sink: sixteen words fit, the next completion waits
    stall = 1;
    repeat (16) pair();
    hw(0, 16'hA5A5);
    chk("full", 1'b0, WR_READY_O);
    q.push_back({KIND_I, rv(sw({16'h5A5A, 16'hA5A5}, s), be)});
    stall = 0;
    hw(1, 16'h5A5A);
    idle();
    repeat (80) @(negedge CLK_I);
    chk("drained", 34'h0, 34'(q.size()));
    wrap_up();
  end
endmodule
`default_nettype wire
